// file: hdl/cmpdaw_bcd_adj.sv
// Combinational packed-BCD correction of the accumulator after an addition.
`timescale 1ns/1ps
module cmpdaw_bcd_adj
(
	input  wire cmpdaw_pkg::cmpdaw_core_t  core_in,
	output logic [7:0]                    acc_out,
	output logic                          carry_out
);
	import cmpdaw_pkg::*;

	logic [4:0] lo_ext;
	logic [4:0] hi_ext;
	logic [4:0] lo_sum;
	logic [4:0] hi_base;
	logic [4:0] hi_sum;
	logic [4:0] lo_carry;

	always_comb
	begin
		lo_ext = {1'b0, core_in.acc[3:0]};
		hi_ext = {1'b0, core_in.acc[7:4]};
		if (nib_gt9(lo_ext) || core_in.digit_carry)
			lo_sum = lo_ext + BCD_FIX;
		else
			lo_sum = lo_ext;
		// The carry out of the low correction is the digit carry fed upward.
		lo_carry = {4'h0, lo_sum[4]};
		hi_base  = hi_ext + lo_carry;
		if (nib_gt9(hi_base) || core_in.carry)
			hi_sum = hi_base + BCD_FIX;
		else
			hi_sum = hi_base;
		acc_out   = {hi_sum[3:0], lo_sum[3:0]};
		carry_out = core_in.carry | hi_sum[4];
	end

endmodule : cmpdaw_bcd_adj

// file: hdl/cmpdaw_exec.sv
// Execution unit for compare-skip-less and decimal-adjust on the four-phase instruction cycle.
//
// Operation
// - Compare-skip-less is decoded from a word whose top seven bits are 0110000, bit 8 the bank bit, low byte the file address.
// - Compare-skip-less subtracts the accumulator from the addressed byte unsigned and writes neither result nor flags.
// - When the byte is below the accumulator the fetched next instruction is discarded and a no-operation cycle runs.
// - Compare-skip-less takes one cycle, two when skipping, three when the skipped instruction has two words.
// - Bank bit 0 selects the access bank and bank bit 1 lets the bank select register choose the bank.
// - Decimal-adjust adds 6 to the low nibble when it exceeds 9 or the digit carry is set.
// - The high nibble becomes high plus the carry out of the low correction, plus 6 more when that exceeds 9 or carry is set.
// - Decimal-adjust is the fixed word 0x0007 with no operands and takes one instruction cycle.
// - Decimal-adjust writes a correct packed-BCD result back to the accumulator.
`timescale 1ns/1ps
module cmpdaw_exec
#(
	parameter logic [7:0] ACCESS_SPLIT = 8'h60
)
(
	input  wire logic                          clk_in,
	input  wire logic                          srst_in,
	input  wire logic                          instr_valid_in,
	input  wire logic [cmpdaw_pkg::WORD_W-1:0] instr_in,
	input  wire logic                          next_two_word_in,
	input  wire cmpdaw_pkg::cmpdaw_core_t      core_in,
	input  wire logic [cmpdaw_pkg::BANK_W-1:0] bank_select_register_in,
	input  wire logic [cmpdaw_pkg::BYTE_W-1:0] mem_rdata_in,
	output logic [cmpdaw_pkg::PHASE_W-1:0]     phase_out,
	output logic                               instr_ready_out,
	output logic [cmpdaw_pkg::ADDR_W-1:0]      mem_addr_out,
	output logic                               mem_re_out,
	output cmpdaw_pkg::cmpdaw_wb_t             wb_out,
	output logic                               discard_out,
	output logic                               busy_out
);
	import cmpdaw_pkg::*;

	logic [PHASE_W-1:0]  phase_q;
	cmpdaw_state_t       state_q;
	cmpdaw_op_t          op_q;
	cmpdaw_op_t          op_d;
	logic                bank_bit_q;
	logic [ADDR_W-1:0]   addr_q;
	logic [ADDR_W-1:0]   addr_d;
	cmpdaw_core_t        core_q;
	logic [BYTE_W-1:0]   operand_q;
	logic                less_q;
	logic                two_word_q;
	cmpdaw_wb_t          wb_q;
	logic [BYTE_W-1:0]   adj_acc;
	logic                adj_carry;
	logic                accept;

	////////////////////////////////////////////////////////////////////////////////
	// Phase counter and decode.

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			phase_q <= PH_Q1;
		else
			phase_q <= phase_q + PH_STEP;
	end

	assign phase_out       = phase_q;
	assign instr_ready_out = (state_q == ST_IDLE) && (phase_q == PH_Q1);
	assign accept          = instr_ready_out && instr_valid_in && (op_d != OP_NONE);

	always_comb
	begin
		if (instr_in[OPC_MSB:OPC_LSB] == CSL_OPCODE)
			op_d = OP_CSL;
		else if (instr_in == DAA_WORD)
			op_d = OP_DAA;
		else
			op_d = OP_NONE;
		if (instr_in[BANK_BIT])
			addr_d = {bank_select_register_in, instr_in[FILE_MSB:0]};
		else if (instr_in[FILE_MSB:0] < ACCESS_SPLIT)
			addr_d = {ACC_LO_BANK, instr_in[FILE_MSB:0]};
		else
			addr_d = {ACC_HI_BANK, instr_in[FILE_MSB:0]};
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			op_q       <= OP_NONE;
			addr_q     <= '0;
			bank_bit_q <= 1'b0;
			core_q     <= '0;
		end
		else if (accept)
		begin
			op_q       <= op_d;
			addr_q     <= addr_d;
			bank_bit_q <= instr_in[BANK_BIT];
			core_q     <= core_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer over the instruction cycles.

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			state_q <= ST_IDLE;
		else
		begin
			case (state_q)
				ST_IDLE:
					if (accept)
						state_q <= ST_EXEC;
				ST_EXEC:
					if (phase_q == PH_Q4)
						state_q <= (op_q == OP_CSL && less_q) ? ST_SKIP : ST_IDLE;
				ST_SKIP:
					if (phase_q == PH_Q4)
						state_q <= two_word_q ? ST_SKIP2 : ST_IDLE;
				ST_SKIP2:
					if (phase_q == PH_Q4)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			two_word_q <= 1'b0;
		else if (state_q == ST_EXEC && phase_q == PH_Q4)
			two_word_q <= next_two_word_in;
	end

	assign discard_out  = (state_q == ST_SKIP) || (state_q == ST_SKIP2);
	assign busy_out     = state_q != ST_IDLE;
	assign mem_addr_out = addr_q;
	assign mem_re_out   = (state_q == ST_EXEC) && (phase_q == PH_Q2) && (op_q == OP_CSL);

	////////////////////////////////////////////////////////////////////////////////
	// Operand read, compare and write-back.

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			operand_q <= '0;
		else if (state_q == ST_EXEC && phase_q == PH_Q2)
			operand_q <= (op_q == OP_CSL) ? mem_rdata_in : core_q.acc;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			less_q <= 1'b0;
		else if (state_q == ST_EXEC && phase_q == PH_Q3)
			less_q <= operand_q < core_q.acc;
	end

	cmpdaw_bcd_adj u_bcd
	(
		.core_in   ({operand_q, core_q.carry, core_q.digit_carry}),
		.acc_out   (adj_acc),
		.carry_out (adj_carry)
	);

	// Write-back stands for the Q4 phase only; compare never writes.
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			wb_q <= '0;
		else if (state_q == ST_EXEC && phase_q == PH_Q3 && op_q == OP_DAA)
			wb_q <= {1'b1, adj_acc, 1'b1, adj_carry};
		else
			wb_q <= '0;
	end

	assign wb_out = wb_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [3:0] exp_hi;
	assign exp_hi = operand_q[7:4];

	csl_decode_a: assert property (@(posedge clk_in) disable iff (srst_in)
		instr_ready_out && instr_valid_in && instr_in[OPC_MSB:OPC_LSB] == CSL_OPCODE
		|=> state_q == ST_EXEC && op_q == OP_CSL && mem_re_out)
		else $error("compare-skip-less not decoded");

	csl_nowrite_a: assert property (@(posedge clk_in) disable iff (srst_in)
		op_q == OP_CSL |-> !wb_out.acc_we && !wb_out.carry_we)
		else $error("compare wrote accumulator or flags");

	skip_start_a: assert property (@(posedge clk_in) disable iff (srst_in)
		state_q == ST_EXEC && phase_q == PH_Q4 && op_q == OP_CSL && less_q |=> discard_out [*4])
		else $error("skip did not discard a full cycle");

	noskip_len_a: assert property (@(posedge clk_in) disable iff (srst_in)
		state_q == ST_EXEC && phase_q == PH_Q4 && !less_q |=> instr_ready_out && !discard_out)
		else $error("non-skipping instruction not done in one cycle");

	skip_two_a: assert property (@(posedge clk_in) disable iff (srst_in)
		state_q == ST_SKIP && phase_q == PH_Q4 && two_word_q |=> discard_out [*4] ##1 instr_ready_out)
		else $error("two-word skip not three cycles");

	bank_sel_a: assert property (@(posedge clk_in) disable iff (srst_in)
		mem_re_out |-> mem_addr_out[ADDR_W-1:BYTE_W] ==
		(bank_bit_q ? $past(bank_select_register_in, 1) :
		(mem_addr_out[FILE_MSB:0] < ACCESS_SPLIT ? ACC_LO_BANK : ACC_HI_BANK)))
		else $error("wrong bank selected");

	daa_low_a: assert property (@(posedge clk_in) disable iff (srst_in)
		wb_out.acc_we |-> wb_out.acc[3:0] == ((operand_q[3:0] > 4'h9 || core_q.digit_carry) ?
		operand_q[3:0] + 4'h6 : operand_q[3:0]))
		else $error("low nibble correction wrong");

	daa_high_a: assert property (@(posedge clk_in) disable iff (srst_in)
		wb_out.acc_we && !core_q.carry && operand_q[3:0] <= 4'h9 && !core_q.digit_carry && exp_hi <= 4'h9
		|-> wb_out.acc[7:4] == exp_hi && !wb_out.carry)
		else $error("high nibble changed without need");

	daa_cycle_a: assert property (@(posedge clk_in) disable iff (srst_in)
		accept && instr_in == DAA_WORD |-> ##3 wb_out.acc_we ##1 instr_ready_out)
		else $error("decimal-adjust not written in one cycle");

	daa_carry_a: assert property (@(posedge clk_in) disable iff (srst_in)
		wb_out.acc_we && (core_q.carry || exp_hi > 4'h9) |-> wb_out.carry && wb_out.carry_we)
		else $error("decimal carry not set");

	csl_skip_c: cover property (@(posedge clk_in) disable iff (srst_in) $rose(discard_out));
	csl_pass_c: cover property (@(posedge clk_in) disable iff (srst_in)
		state_q == ST_EXEC && phase_q == PH_Q4 && op_q == OP_CSL && !less_q);
	skip_two_c: cover property (@(posedge clk_in) disable iff (srst_in) state_q == ST_SKIP2);
	daa_carry_c: cover property (@(posedge clk_in) disable iff (srst_in) wb_out.acc_we && wb_out.carry);

endmodule : cmpdaw_exec

// file: hdl/cmpdaw_pkg.sv
// Constants, types and shared functions of the compare-skip and decimal-adjust execution unit.
package cmpdaw_pkg;

	localparam int unsigned WORD_W   = 16;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned BANK_W   = 4;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned PHASE_W  = 2;

	// Four clock phases form one instruction cycle.
	localparam logic [PHASE_W-1:0] PH_Q1 = 2'h0;
	localparam logic [PHASE_W-1:0] PH_Q2 = 2'h1;
	localparam logic [PHASE_W-1:0] PH_Q3 = 2'h2;
	localparam logic [PHASE_W-1:0] PH_Q4 = 2'h3;
	localparam logic [PHASE_W-1:0] PH_STEP = 2'h1;

	// Instruction fields and fixed patterns.
	localparam int unsigned  OPC_MSB      = 15;
	localparam int unsigned  OPC_LSB      = 9;
	localparam int unsigned  BANK_BIT     = 8;
	localparam int unsigned  FILE_MSB     = 7;
	localparam logic [6:0]   CSL_OPCODE   = 7'h30;
	localparam logic [15:0]  DAA_WORD     = 16'h0007;

	// Access bank: low addresses map to bank 0, the rest to the top bank.
	localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;

	// Packed-BCD correction constants.
	localparam logic [4:0] BCD_MAX  = 5'h09;
	localparam logic [4:0] BCD_FIX  = 5'h06;
	localparam logic [4:0] NIB_ZERO = 5'h00;

	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_EXEC  = 2'h1,
		ST_SKIP  = 2'h3,
		ST_SKIP2 = 2'h2
	} cmpdaw_state_t;

	typedef enum logic [1:0]
	{
		OP_NONE = 2'h0,
		OP_CSL  = 2'h1,
		OP_DAA  = 2'h2
	} cmpdaw_op_t;

	// Accumulator and arithmetic flags as seen by the unit.
	typedef struct packed
	{
		logic [7:0] acc;
		logic       carry;
		logic       digit_carry;
	} cmpdaw_core_t;

	// Write-back towards the accumulator and the carry flag.
	typedef struct packed
	{
		logic       acc_we;
		logic [7:0] acc;
		logic       carry_we;
		logic       carry;
	} cmpdaw_wb_t;

	function automatic logic nib_gt9(input logic [4:0] v);
		return v > BCD_MAX;
	endfunction : nib_gt9

endpackage : cmpdaw_pkg

// file: verif/tb_top.sv
// Self-checking testbench of the compare-skip and decimal-adjust execution unit.
`timescale 1ns/1ps
module tb_top;
	import cmpdaw_pkg::*;

	logic                clk_in = 1'b0;
	logic                srst_in = 1'b1;
	logic                instr_valid_in = 1'b0;
	logic [WORD_W-1:0]   instr_in = 16'h0000;
	logic                next_two_word_in = 1'b0;
	cmpdaw_core_t        core_in = '0;
	logic [BANK_W-1:0]   bank_select_register_in = 4'h0;
	logic [BYTE_W-1:0]   mem_rdata_in = 8'h00;
	logic [PHASE_W-1:0]  phase_out;
	logic                instr_ready_out;
	logic [ADDR_W-1:0]   mem_addr_out;
	logic                mem_re_out;
	cmpdaw_wb_t          wb_out;
	logic                discard_out;
	logic                busy_out;
	int                  err_count = 0;
	int                  n_compared = 0;

	cmpdaw_exec dut (.clk_in(clk_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.next_two_word_in(next_two_word_in), .core_in(core_in), .bank_select_register_in(bank_select_register_in),
		.mem_rdata_in(mem_rdata_in), .phase_out(phase_out), .instr_ready_out(instr_ready_out),
		.mem_addr_out(mem_addr_out), .mem_re_out(mem_re_out), .wb_out(wb_out), .discard_out(discard_out),
		.busy_out(busy_out));

	always #25 clk_in = ~clk_in;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// Issues one word at the next ready edge and watches the unit for sixteen clocks.
	task automatic run(input logic [15:0] word, input logic [7:0] acc, input logic c, input logic dc,
		input logic [3:0] bank_select_register, input logic [7:0] rd, input logic two, output int nbusy, output int ndisc,
		output int nre, output int nwb, output logic [11:0] addr, output cmpdaw_wb_t wb);
		int i;
		nbusy = 0;
		ndisc = 0;
		nre = 0;
		nwb = 0;
		addr = 'x;
		wb = '0;
		i = 0;
		while (instr_ready_out !== 1'b1 && i < 8)
		begin
			@(posedge clk_in);
			#1;
			i++;
		end
		chk("ready_at_issue", 16'(instr_ready_out), 16'h0001);
		chk("phase_at_issue", 16'(phase_out), 16'(PH_Q1));
		instr_in = word;
		core_in = '{acc: acc, carry: c, digit_carry: dc};
		bank_select_register_in = bank_select_register;
		mem_rdata_in = rd;
		next_two_word_in = two;
		instr_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		instr_valid_in = 1'b0;
		for (i = 0; i < 16; i++)
		begin
			if (busy_out === 1'b1) nbusy++;
			if (discard_out === 1'b1) ndisc++;
			if (mem_re_out === 1'b1)
			begin
				nre++;
				addr = mem_addr_out;
			end
			if (wb_out.acc_we === 1'b1 || wb_out.carry_we === 1'b1)
			begin
				nwb++;
				wb = wb_out;
			end
			@(posedge clk_in);
			#1;
		end
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp_case(input logic a, input logic [7:0] f, input logic [3:0] bank_select_register, input logic [7:0] rd,
		input logic [7:0] acc, input logic two, input logic [11:0] exp_addr);
		int nb, nd, nr, nw;
		logic [11:0] ad;
		cmpdaw_wb_t wb;
		logic skip;
		skip = rd < acc;
		run({CSL_OPCODE, a, f}, acc, 1'b1, 1'b1, bank_select_register, rd, two, nb, nd, nr, nw, ad, wb);
		chk("mem_re_count", 16'(nr), 16'h0001);
		chk("mem_addr", 16'(ad), 16'(exp_addr));
		chk("wb_count", 16'(nw), 16'h0000);
		chk("discard_clocks", 16'(nd), skip ? (two ? 16'h0008 : 16'h0004) : 16'h0000);
		chk("busy_clocks", 16'(nb), skip ? (two ? 16'h000B : 16'h0007) : 16'h0003);
	endtask : cmp_case

	task automatic daa_case(input logic [7:0] acc, input logic c, input logic dc);
		int nb, nd, nr, nw;
		logic [11:0] ad;
		cmpdaw_wb_t wb;
		logic [4:0] lo, hi;
		logic dc2;
		lo = {1'b0, acc[3:0]};
		if (lo > 5'h09 || dc) lo = lo + 5'h06;
		dc2 = lo[4];
		hi = {1'b0, acc[7:4]} + 5'(dc2);
		if (hi > 5'h09 || c) hi = hi + 5'h06;
		run(16'h0007, acc, c, dc, 4'h3, 8'h00, 1'b0, nb, nd, nr, nw, ad, wb);
		chk("daa_wb_count", 16'(nw), 16'h0001);
		chk("daa_busy", 16'(nb), 16'h0003);
		chk("daa_acc", 16'(wb.acc), 16'({hi[3:0], lo[3:0]}));
		chk("daa_carry", {15'h0000, wb.carry}, {15'h0000, c | hi[4]});
		chk("daa_carry_we", {15'h0000, wb.carry_we}, 16'h0001);
		chk("daa_mem_re", 16'(nr), 16'h0000);
		chk("daa_discard", 16'(nd), 16'h0000);
	endtask : daa_case

	task automatic ignored_case();
		int nb, nd, nr, nw;
		logic [11:0] ad;
		cmpdaw_wb_t wb;
		run(16'h6433, 8'h20, 1'b0, 1'b0, 4'h1, 8'h10, 1'b0, nb, nd, nr, nw, ad, wb);
		chk("ignored_busy", 16'(nb + nr + nw + nd), 16'h0000);
	endtask : ignored_case

	// Resets the unit in the middle of a skip and checks that it restarts idle.
	task automatic reset_case();
		int i;
		i = 0;
		while (instr_ready_out !== 1'b1 && i < 8)
		begin
			@(posedge clk_in);
			#1;
			i++;
		end
		instr_in = {CSL_OPCODE, 1'b0, 8'h10};
		core_in = '{acc: 8'h02, carry: 1'b0, digit_carry: 1'b0};
		mem_rdata_in = 8'h01;
		next_two_word_in = 1'b0;
		instr_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		instr_valid_in = 1'b0;
		repeat (5) @(posedge clk_in);
		#1;
		chk("skip_before_reset", 16'(discard_out), 16'h0001);
		srst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		srst_in = 1'b0;
		chk("reset_discard", 16'(discard_out), 16'h0000);
		chk("reset_busy", 16'(busy_out), 16'h0000);
		chk("reset_ready", 16'(instr_ready_out), 16'h0001);
		chk("reset_phase", 16'(phase_out), 16'(PH_Q1));
		chk("reset_wb", 16'(wb_out), 16'h0000);
	endtask : reset_case

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk_in);
		#1;
		srst_in = 1'b0;
		chk("start_ready", 16'(instr_ready_out), 16'h0001);
		chk("start_busy", 16'(busy_out), 16'h0000);
		chk("start_wb", 16'(wb_out), 16'h0000);
		cmp_case(1'b1, 8'h33, 4'h5, 8'h10, 8'h20, 1'b0, 12'h533);
		cmp_case(1'b0, 8'h5F, 4'h5, 8'h44, 8'h44, 1'b0, 12'h05F);
		cmp_case(1'b0, 8'h60, 4'h5, 8'hFF, 8'h00, 1'b0, 12'hF60);
		cmp_case(1'b1, 8'hA1, 4'hC, 8'h7F, 8'h80, 1'b1, 12'hCA1);
		cmp_case(1'b0, 8'h00, 4'h2, 8'h00, 8'h01, 1'b1, 12'h000);
		daa_case(8'hA5, 1'b0, 1'b0);
		daa_case(8'hCE, 1'b0, 1'b0);
		daa_case(8'h12, 1'b0, 1'b0);
		daa_case(8'h08, 1'b0, 1'b1);
		daa_case(8'h30, 1'b1, 1'b0);
		daa_case(8'h9A, 1'b0, 1'b0);
		ignored_case();
		reset_case();
		cmp_case(1'b1, 8'h40, 4'h7, 8'h05, 8'h06, 1'b0, 12'h740);
		end_of_test();
	end

	initial
	begin
		#(50 * 2000);
		err_count++;
		end_of_test();
	end

endmodule : tb_top
